// >>> tb/hpsg_sink_model.sv
// transmitter-side model: collects serial audio words and checks slot framing
`timescale 1ns/10ps
`default_nettype none
module hpsg_sink_model (
  input  wire logic   i2s_bclk,
  input  wire logic   i2s_lrck,
  input  wire logic   i2s_sdata,
  output var  logic [15:0] left_word,
  output var  logic [15:0] right_word,
  output var  int     frame_cnt,
  output var  int     slot_err
);
  // word length the sink is configured for
  localparam int CFG_BITS = 16;

  logic [15:0] shreg;
  logic        lr_prev;
  int          bit_cnt;

  // fresh configuration state, as after a plug-in
  initial begin
    shreg      = 16'h0000;
    lr_prev    = 1'b0;
    bit_cnt    = 0;
    left_word  = 16'h0000;
    right_word = 16'h0000;
    frame_cnt  = 0;
    slot_err   = 0;
  end

  // ---------------------------------------------------------------
  // capture on rising bit clock; word ends where word select turned
  // ---------------------------------------------------------------
  always @(posedge i2s_bclk) begin
    shreg <= {shreg[14:0], i2s_sdata};
    if (i2s_lrck !== lr_prev) begin
      if (bit_cnt != CFG_BITS - 1 && frame_cnt > 0) slot_err <= slot_err + 1;
      if (i2s_lrck === 1'b1) begin
        left_word <= {shreg[14:0], i2s_sdata};
      end else begin
        right_word <= {shreg[14:0], i2s_sdata};
        frame_cnt  <= frame_cnt + 1;
      end
      bit_cnt <= 0;
    end else begin
      bit_cnt <= bit_cnt + 1;
    end
    lr_prev <= i2s_lrck;
  end
endmodule : hpsg_sink_model
`default_nettype wire

// >>> tb/testbench.sv
// self-checking bench of the pattern and audio source
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import hpsg_pkg::*;
  localparam int DEB_SIM = 8;
  localparam int RATE_KHZ [0:4] = '{25000, 27000, 65000, 108000, 148500};
  // frame period the sink is set up for: 16 core cycles per reference period
  localparam int CFG_FRAME_CYC = 16 * 2 * AUD_REF_HALF * AUD_SLOT_BITS;

  logic core_clk, resetn, btn_n, aud_en, ref_clk;
  logic vid_pix_ce, vid_de, vid_hsync, vid_vsync, pix_clk_locked;
  logic i2s_bclk, i2s_lrck, i2s_sdata;
  hpsg_pix_t         vid_data;
  logic [MODE_W-1:0] timing_mode_index;
  logic [15:0]       left_word, right_word;
  int                frame_cnt, slot_err, error_cnt, num_checks;

  initial begin
    core_clk = 1'b0;
    ref_clk  = 1'b0;
  end
  always #2.5 core_clk = ~core_clk;
  always #40 ref_clk = ~ref_clk;

  hpsg_top #(.DEB_CYCLES(DEB_SIM)) i_dut (
    .core_clk(core_clk), .resetn(resetn), .mode_select_button_n(btn_n),
    .audio_enable_switch(aud_en), .aud_ref_clk(ref_clk), .vid_pix_ce(vid_pix_ce),
    .vid_data(vid_data), .vid_de(vid_de), .vid_hsync(vid_hsync), .vid_vsync(vid_vsync),
    .pix_clk_locked(pix_clk_locked), .timing_mode_index(timing_mode_index),
    .i2s_bclk(i2s_bclk), .i2s_lrck(i2s_lrck), .i2s_sdata(i2s_sdata));

  hpsg_sink_model i_sink (
    .i2s_bclk(i2s_bclk), .i2s_lrck(i2s_lrck), .i2s_sdata(i2s_sdata),
    .left_word(left_word), .right_word(right_word), .frame_cnt(frame_cnt),
    .slot_err(slot_err));

  // ---------------------------------------------------------------
  // shared helpers
  // ---------------------------------------------------------------
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : report_and_stop

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk

  task automatic timeout(input string what);
    error_cnt++;
    $display("[ERR] %s expected done seen timeout", what);
    report_and_stop;
  endtask : timeout

  task automatic wait_lock(output int n);
    n = 0;
    while (pix_clk_locked !== 1'b1) begin
      @(negedge core_clk);
      n++;
      if (n > 2100) timeout("lock wait");
    end
  endtask : wait_lock

  task automatic next_pix(output hpsg_pix_t d, output logic de);
    int n;
    n = 0;
    do begin
      @(negedge core_clk);
      n++;
    end while (vid_pix_ce !== 1'b1 && n < 50);
    if (n >= 50) timeout("pixel wait");
    d  = vid_data;
    de = vid_de;
  endtask : next_pix

  task automatic press(input int low_cyc);
    @(negedge core_clk);
    btn_n = 1'b0;
    repeat (low_cyc) @(negedge core_clk);
    btn_n = 1'b1;
    repeat (20) @(negedge core_clk);
  endtask : press

  task automatic wait_frames(input int k, output int t);
    int target;
    target = frame_cnt + k;
    t = 0;
    while (frame_cnt < target) begin
      @(negedge core_clk);
      t++;
      if (t > k * 5000) timeout("frame wait");
    end
  endtask : wait_frames

  function automatic logic in_sine(input logic [15:0] w);
    int k;
    in_sine = 1'b0;
    for (k = 0; k < 9; k++) begin
      if (w === SINE_Q[k] || 16'(w + SINE_Q[k]) === 16'h0000) in_sine = 1'b1;
    end
  endfunction : in_sine

  task automatic t_rate(input int m);
    int c, i, e;
    c = 0;
    for (i = 0; i < 2000; i++) begin
      @(negedge core_clk);
      if (vid_pix_ce === 1'b1) c++;
    end
    e = RATE_KHZ[m] / 100;
    chk("pix_rate_in_band", 1, (c >= e - 2 && c <= e + 2));
  endtask : t_rate

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    int n, h, s, w;
    hpsg_pix_t d;
    logic de;
    repeat (4) @(negedge core_clk);
    chk("mode_at_reset", 0, timing_mode_index);
    chk("locked_at_reset", 0, pix_clk_locked);
    resetn = 1'b1;
    wait_lock(n);
    chk("lock_time_ok", 1, (n >= 1995 && n <= 2005));
    for (h = 0; h < 6; h++) begin
      next_pix(d, de);
      chk("pix_de", 1, de);
      chk("pix_word", {8'(h), 8'h00, 8'(h)}, d);
    end
    s = 0;
    w = 0;
    for (h = 6; h < 800; h++) begin
      next_pix(d, de);
      if (vid_hsync === 1'b0) begin
        if (w == 0) s = h;
        w++;
      end
    end
    chk("hsync_start", 656, s);
    chk("hsync_width", 96, w);
    $display("test reset and pixel layout done");
  endtask : t_reset

  task automatic t_modes;
    int m, n;
    hpsg_pix_t d;
    logic de;
    t_rate(0);
    for (m = 1; m <= 5; m++) begin
      press(20);
      chk("mode_step", m % 5, timing_mode_index);
      chk("locked_low", 0, pix_clk_locked);
      wait_lock(n);
      next_pix(d, de);
      chk("restart_pix", 32'h0100_0000, {7'h00, de, d});
      chk("hsync_idle", (m % 5 >= 3) ? 0 : 1, vid_hsync);
      chk("vsync_idle", (m % 5 >= 3) ? 0 : 1, vid_vsync);
      t_rate(m % 5);
    end
    $display("test mode stepping done");
  endtask : t_modes

  task automatic t_bounce;
    int n;
    press(3);
    chk("mode_after_bounce", 0, timing_mode_index);
    chk("locked_after_bounce", 1, pix_clk_locked);
    press(60);
    chk("mode_after_long", 1, timing_mode_index);
    wait_lock(n);
    $display("test button debounce done");
  endtask : t_bounce

  task automatic t_audio;
    int i, t;
    logic [15:0] prev;
    aud_en = 1'b1;
    wait_frames(3, t);
    wait_frames(1, t);
    chk("frame_period_ok", 1, (t >= CFG_FRAME_CYC - 16 && t <= CFG_FRAME_CYC + 16));
    prev = left_word;
    for (i = 0; i < 4; i++) begin
      wait_frames(1, t);
      chk("right_equals_left", left_word, right_word);
      chk("word_in_sine", 1, in_sine(left_word));
      chk("word_advances", 1, (left_word !== prev));
      prev = left_word;
    end
    chk("slot_errors", 0, slot_err);
    aud_en = 1'b0;
    wait_frames(4, t);
    chk("mute_left", 0, left_word);
    chk("mute_right", 0, right_word);
    $display("test audio stream done");
  endtask : t_audio

  initial begin
    error_cnt  = 0;
    num_checks = 0;
    resetn     = 1'b0;
    btn_n      = 1'b1;
    aud_en     = 1'b0;
    t_reset;
    t_modes;
    t_bounce;
    t_audio;
    report_and_stop;
  end
endmodule : testbench
`default_nettype wire

// >>> verilog/hpsg_buf2.sv
// two-entry valid/ready buffer
`timescale 1ns/10ps
`default_nettype none
module hpsg_buf2 #(
  parameter int W = 32
) (
  input  wire logic         core_clk,
  input  wire logic         resetn,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  logic [W-1:0] mem_ff [0:1];
  logic [W-1:0] nxt_mem [0:1];
  logic         wp_ff, nxt_wp, rp_ff, nxt_rp;
  logic [1:0]   cnt_ff, nxt_cnt;
  logic         push, pop;

  assign in_ready  = (cnt_ff != 2'h2);
  assign out_valid = (cnt_ff != 2'h0);
  assign out_data  = mem_ff[rp_ff];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_comb begin
    nxt_mem = mem_ff;
    nxt_wp  = wp_ff;
    nxt_rp  = rp_ff;
    nxt_cnt = cnt_ff;
    if (push) begin
      nxt_mem[wp_ff] = in_data;
      nxt_wp         = ~wp_ff;
    end
    if (pop) begin
      nxt_rp = ~rp_ff;
    end
    nxt_cnt = 2'(cnt_ff + {1'b0, push} - {1'b0, pop});
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      mem_ff[0] <= '0;
      mem_ff[1] <= '0;
      wp_ff     <= 1'b0;
      rp_ff     <= 1'b0;
      cnt_ff    <= 2'h0;
    end else begin
      mem_ff <= nxt_mem;
      wp_ff  <= nxt_wp;
      rp_ff  <= nxt_rp;
      cnt_ff <= nxt_cnt;
    end
  end
endmodule : hpsg_buf2
`default_nettype wire

// >>> verilog/hpsg_pkg.sv
// package: constants, carriers and mode table of the pattern and audio source
`default_nettype none
package hpsg_pkg;
  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int CLK_KHZ   = 200000;
  localparam int DEB_MS    = 20;
  localparam int DEB_CYC   = DEB_MS * CLK_KHZ;
  localparam int LOCK_US   = 10;
  localparam int LOCK_CYC  = (LOCK_US * CLK_KHZ + 999) / 1000;
  localparam int LOCK_W    = 12;
  localparam int PHASE_W   = 16;
  // ---------------------------------------------------------------
  // display modes
  // ---------------------------------------------------------------
  localparam int          MODE_W    = 3;
  localparam logic [2:0]  MODE_LAST = 3'h4;
  localparam int          PIX_W     = 8;
  // ---------------------------------------------------------------
  // audio
  // ---------------------------------------------------------------
  localparam int AUD_FS_HZ     = 48000;
  localparam int AUD_BITS      = 16;
  localparam int AUD_CHANS     = 2;
  localparam int AUD_SLOT_BITS = AUD_BITS * AUD_CHANS;
  localparam int AUD_REF_HZ    = 12288000;
  localparam int AUD_REF_HALF  = AUD_REF_HZ / (AUD_FS_HZ * AUD_SLOT_BITS * 2);
  localparam int SLOT_W        = 5;
  localparam int LUT_W         = 5;
  localparam logic [15:0] SINE_Q [0:8] = '{16'h0000, 16'h18F9, 16'h30FB, 16'h471C,
                                           16'h5A82, 16'h6A6D, 16'h7641, 16'h7D8A,
                                           16'h7FFF};
  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0] red;
    logic [7:0] green;
    logic [7:0] blue;
  } hpsg_pix_t;

  typedef struct packed {
    logic [11:0] h_act;
    logic [11:0] h_fp;
    logic [11:0] h_sync;
    logic [11:0] h_bp;
    logic [11:0] v_act;
    logic [11:0] v_fp;
    logic [11:0] v_sync;
    logic [11:0] v_bp;
    logic        hs_pos;
    logic        vs_pos;
    logic [15:0] inc;
  } hpsg_timing_t;

  typedef enum logic [1:0] {VST_LOCK = 2'b00, VST_RUN = 2'b01} hpsg_vst_t;

  // phase increment of the pixel-rate accumulator
  function automatic logic [15:0] hpsg_inc(input int pclk_khz);
    return 16'((longint'(pclk_khz) << PHASE_W) / CLK_KHZ);
  endfunction : hpsg_inc

  function automatic hpsg_timing_t hpsg_timing(input logic [2:0] m);
    hpsg_timing_t t;
    case (m)
      3'h0:    t = '{12'd640, 12'd16, 12'd96, 12'd48, 12'd480, 12'd10, 12'd2, 12'd33,
                     1'b0, 1'b0, hpsg_inc(25000)};
      3'h1:    t = '{12'd720, 12'd16, 12'd62, 12'd60, 12'd480, 12'd9, 12'd6, 12'd30,
                     1'b0, 1'b0, hpsg_inc(27000)};
      3'h2:    t = '{12'd1024, 12'd24, 12'd136, 12'd160, 12'd768, 12'd3, 12'd6, 12'd29,
                     1'b0, 1'b0, hpsg_inc(65000)};
      3'h3:    t = '{12'd1280, 12'd48, 12'd112, 12'd248, 12'd1024, 12'd1, 12'd3, 12'd38,
                     1'b1, 1'b1, hpsg_inc(108000)};
      default: t = '{12'd1920, 12'd88, 12'd44, 12'd148, 12'd1080, 12'd4, 12'd5, 12'd36,
                     1'b1, 1'b1, hpsg_inc(148500)};
    endcase
    return t;
  endfunction : hpsg_timing
endpackage : hpsg_pkg
`default_nettype wire

// >>> verilog/hpsg_top.sv
// test video pattern and sine-tone audio source for an external transmitter
`timescale 1ns/10ps
`default_nettype none
module hpsg_top
  import hpsg_pkg::*;
#(
  parameter int DEB_CYCLES = DEB_CYC
) (
  input  wire logic         core_clk,
  input  wire logic         resetn,
  input  wire logic         mode_select_button_n,
  input  wire logic         audio_enable_switch,
  input  wire logic         aud_ref_clk,
  output logic              vid_pix_ce,
  output hpsg_pix_t         vid_data,
  output logic              vid_de,
  output logic              vid_hsync,
  output logic              vid_vsync,
  output logic              pix_clk_locked,
  output logic [MODE_W-1:0] timing_mode_index,
  output logic              i2s_bclk,
  output logic              i2s_lrck,
  output logic              i2s_sdata
);
  localparam int DEB_W = $clog2(DEB_CYCLES + 1);

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  logic btn_s1_ff, btn_s2_ff, sw_s1_ff, sw_s2_ff, ref_s1_ff, ref_s2_ff, ref_s3_ff;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      btn_s1_ff <= 1'b1;
      btn_s2_ff <= 1'b1;
      sw_s1_ff  <= 1'b0;
      sw_s2_ff  <= 1'b0;
      ref_s1_ff <= 1'b0;
      ref_s2_ff <= 1'b0;
      ref_s3_ff <= 1'b0;
    end else begin
      btn_s1_ff <= mode_select_button_n;
      btn_s2_ff <= btn_s1_ff;
      sw_s1_ff  <= audio_enable_switch;
      sw_s2_ff  <= sw_s1_ff;
      ref_s1_ff <= aud_ref_clk;
      ref_s2_ff <= ref_s1_ff;
      ref_s3_ff <= ref_s2_ff;
    end
  end

  // ---------------------------------------------------------------
  // button debounce and mode select
  // ---------------------------------------------------------------
  logic             btn_stable_ff, nxt_btn_stable;
  logic [DEB_W-1:0] deb_cnt_ff, nxt_deb_cnt;
  logic             press;

  always_comb begin
    nxt_btn_stable = btn_stable_ff;
    nxt_deb_cnt    = '0;
    press          = 1'b0;
    if (btn_s2_ff != btn_stable_ff) begin
      nxt_deb_cnt = DEB_W'(deb_cnt_ff + 1'b1);
      if (deb_cnt_ff == DEB_W'(DEB_CYCLES - 1)) begin
        nxt_btn_stable = btn_s2_ff;
        nxt_deb_cnt    = '0;
        press          = ~btn_s2_ff;
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      btn_stable_ff <= 1'b1;
      deb_cnt_ff    <= '0;
    end else begin
      btn_stable_ff <= nxt_btn_stable;
      deb_cnt_ff    <= nxt_deb_cnt;
    end
  end

  // ---------------------------------------------------------------
  // pixel rate generator and timing counters
  // ---------------------------------------------------------------
  hpsg_vst_t         vst_ff, nxt_vst;
  logic [MODE_W-1:0] mode_ff, nxt_mode;
  logic [LOCK_W-1:0] lock_ff, nxt_lock;
  logic [15:0]       phase_ff, nxt_phase;
  logic [11:0]       h_ff, nxt_h, v_ff, nxt_v, h_tot, v_tot;
  logic              ce_ff, nxt_ce, de_ff, nxt_de, hs_ff, nxt_hs, vs_ff, nxt_vs;
  hpsg_pix_t         pix_ff, nxt_pix;
  hpsg_timing_t      tm;
  logic              carry, in_hs, in_vs;

  assign tm    = hpsg_timing(mode_ff);
  assign h_tot = 12'(tm.h_act + tm.h_fp + tm.h_sync + tm.h_bp);
  assign v_tot = 12'(tm.v_act + tm.v_fp + tm.v_sync + tm.v_bp);
  assign in_hs = (h_ff >= 12'(tm.h_act + tm.h_fp)) &&
                 (h_ff < 12'(tm.h_act + tm.h_fp + tm.h_sync));
  assign in_vs = (v_ff >= 12'(tm.v_act + tm.v_fp)) &&
                 (v_ff < 12'(tm.v_act + tm.v_fp + tm.v_sync));

  always_comb begin
    nxt_vst   = vst_ff;
    nxt_mode  = mode_ff;
    nxt_lock  = lock_ff;
    nxt_phase = phase_ff;
    nxt_h     = h_ff;
    nxt_v     = v_ff;
    nxt_ce    = 1'b0;
    nxt_de    = de_ff;
    nxt_hs    = hs_ff;
    nxt_vs    = vs_ff;
    nxt_pix   = pix_ff;
    carry     = 1'b0;
    case (vst_ff)
      VST_LOCK: begin
        nxt_lock  = LOCK_W'(lock_ff + 1'b1);
        nxt_phase = '0;
        nxt_h     = '0;
        nxt_v     = '0;
        nxt_de    = 1'b0;
        nxt_hs    = ~tm.hs_pos;
        nxt_vs    = ~tm.vs_pos;
        nxt_pix   = '0;
        if (lock_ff == LOCK_W'(LOCK_CYC - 1)) begin
          nxt_vst = VST_RUN;
        end
      end
      VST_RUN: begin
        {carry, nxt_phase} = 17'({1'b0, phase_ff} + {1'b0, tm.inc});
        if (carry) begin
          nxt_ce = 1'b1;
          nxt_de = (h_ff < tm.h_act) && (v_ff < tm.v_act);
          nxt_hs = in_hs ? tm.hs_pos : ~tm.hs_pos;
          nxt_vs = in_vs ? tm.vs_pos : ~tm.vs_pos;
          if ((h_ff < tm.h_act) && (v_ff < tm.v_act)) begin
            nxt_pix = '{red: h_ff[7:0], green: v_ff[7:0], blue: h_ff[7:0] ^ v_ff[7:0]};
          end else begin
            nxt_pix = '0;
          end
          if (h_ff == 12'(h_tot - 1'b1)) begin
            nxt_h = '0;
            nxt_v = (v_ff == 12'(v_tot - 1'b1)) ? 12'h000 : 12'(v_ff + 1'b1);
          end else begin
            nxt_h = 12'(h_ff + 1'b1);
          end
        end
      end
      default: begin
        nxt_vst = VST_LOCK;
      end
    endcase
    if (press) begin
      nxt_mode = (mode_ff == MODE_LAST) ? 3'h0 : 3'(mode_ff + 1'b1);
      nxt_vst  = VST_LOCK;
      nxt_lock = '0;
      nxt_ce   = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      vst_ff   <= VST_LOCK;
      mode_ff  <= 3'h0;
      lock_ff  <= '0;
      phase_ff <= 16'h0000;
      h_ff     <= 12'h000;
      v_ff     <= 12'h000;
      ce_ff    <= 1'b0;
      de_ff    <= 1'b0;
      hs_ff    <= 1'b1;
      vs_ff    <= 1'b1;
      pix_ff   <= '0;
    end else begin
      vst_ff   <= nxt_vst;
      mode_ff  <= nxt_mode;
      lock_ff  <= nxt_lock;
      phase_ff <= nxt_phase;
      h_ff     <= nxt_h;
      v_ff     <= nxt_v;
      ce_ff    <= nxt_ce;
      de_ff    <= nxt_de;
      hs_ff    <= nxt_hs;
      vs_ff    <= nxt_vs;
      pix_ff   <= nxt_pix;
    end
  end

  assign vid_pix_ce        = ce_ff;
  assign vid_data          = pix_ff;
  assign vid_de            = de_ff;
  assign vid_hsync         = hs_ff;
  assign vid_vsync         = vs_ff;
  assign pix_clk_locked    = (vst_ff == VST_RUN);
  assign timing_mode_index = mode_ff;

  // ---------------------------------------------------------------
  // sine sample producer
  // ---------------------------------------------------------------
  logic [LUT_W-1:0]         lut_ff, nxt_lut;
  logic [15:0]              mag, smp;
  logic [AUD_SLOT_BITS-1:0] prod_data, buf_data;
  logic                     prod_ready, buf_valid, buf_pop;

  always_comb begin
    mag = lut_ff[3] ? SINE_Q[4'h8 - {1'b0, lut_ff[2:0]}] : SINE_Q[{1'b0, lut_ff[2:0]}];
    smp = lut_ff[4] ? 16'(-mag) : mag;
    prod_data = sw_s2_ff ? {smp, smp} : '0;
    nxt_lut   = prod_ready ? LUT_W'(lut_ff + 1'b1) : lut_ff;
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      lut_ff <= '0;
    end else begin
      lut_ff <= nxt_lut;
    end
  end

  hpsg_buf2 #(.W(AUD_SLOT_BITS)) u_buf (
    .core_clk  (core_clk),
    .resetn    (resetn),
    .in_valid  (1'b1),
    .in_ready  (prod_ready),
    .in_data   (prod_data),
    .out_valid (buf_valid),
    .out_ready (buf_pop),
    .out_data  (buf_data)
  );

  // ---------------------------------------------------------------
  // I2S serialiser on the sampled reference clock
  // ---------------------------------------------------------------
  logic [2:0]               half_ff, nxt_half;
  logic [SLOT_W-1:0]        slot_ff, nxt_slot;
  logic [AUD_SLOT_BITS-1:0] sh_ff, nxt_sh, word;
  logic                     bclk_ff, nxt_bclk, lr_ff, nxt_lr, sd_ff, nxt_sd, ref_rise, fall;

  assign ref_rise = ref_s2_ff & ~ref_s3_ff;

  always_comb begin
    nxt_half = half_ff;
    nxt_bclk = bclk_ff;
    nxt_slot = slot_ff;
    nxt_lr   = lr_ff;
    nxt_sd   = sd_ff;
    nxt_sh   = sh_ff;
    fall     = 1'b0;
    buf_pop  = 1'b0;
    word     = buf_valid ? buf_data : '0;
    if (ref_rise) begin
      nxt_half = 3'(half_ff + 1'b1);
      if (half_ff == 3'(AUD_REF_HALF - 1)) begin
        nxt_half = 3'h0;
        nxt_bclk = ~bclk_ff;
        fall     = bclk_ff;
      end
    end
    if (fall) begin
      nxt_slot = SLOT_W'(slot_ff + 1'b1);
      nxt_lr   = nxt_slot[SLOT_W-1];
      if (nxt_slot == 5'h01) begin
        buf_pop = 1'b1;
        nxt_sd  = word[AUD_SLOT_BITS-1];
        nxt_sh  = {word[AUD_SLOT_BITS-2:0], 1'b0};
      end else begin
        nxt_sd  = sh_ff[AUD_SLOT_BITS-1];
        nxt_sh  = {sh_ff[AUD_SLOT_BITS-2:0], 1'b0};
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      half_ff <= 3'h0;
      bclk_ff <= 1'b0;
      slot_ff <= 5'h00;
      lr_ff   <= 1'b0;
      sd_ff   <= 1'b0;
      sh_ff   <= '0;
    end else begin
      half_ff <= nxt_half;
      bclk_ff <= nxt_bclk;
      slot_ff <= nxt_slot;
      lr_ff   <= nxt_lr;
      sd_ff   <= nxt_sd;
      sh_ff   <= nxt_sh;
    end
  end

  assign i2s_bclk  = bclk_ff;
  assign i2s_lrck  = lr_ff;
  assign i2s_sdata = sd_ff;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  a_blank_black: assert property (!vid_de |-> vid_data == '0)
    else $error("pixel data not black while blanked");
  a_red_msb: assert property (nxt_ce && nxt_de |=> vid_data[23:16] == $past(h_ff[7:0]))
    else $error("red byte not in top position");
  a_mode_range: assert property (timing_mode_index <= MODE_LAST)
    else $error("mode index out of range");
  a_mode_step: assert property (press |=>
      timing_mode_index == (($past(mode_ff) == MODE_LAST) ? 3'h0 : 3'($past(mode_ff) + 1'b1)))
    else $error("mode did not step by one");
  a_lock_hold: assert property (press |=> !pix_clk_locked [*8] ##1 (h_ff == 12'h000))
    else $error("counters ran during retune");
  a_lock_release: assert property (vst_ff == VST_LOCK && lock_ff == LOCK_W'(LOCK_CYC - 1) && !press
      |=> pix_clk_locked && h_ff == 12'h000 && v_ff == 12'h000)
    else $error("retune did not end at frame start");
  a_press_once: assert property (press |=> !press [*8])
    else $error("one press advanced twice");
  a_lr_edge: assert property ($changed(i2s_lrck) |-> slot_ff == 5'h00 || slot_ff == 5'h10)
    else $error("word select moved inside a channel");
  a_msb_first: assert property (fall && nxt_slot == 5'h01 |=> i2s_sdata == $past(word[31]))
    else $error("sample did not start with msb");
  a_lut_step: assert property (prod_ready |=> lut_ff == 5'($past(lut_ff) + 1'b1))
    else $error("sine index did not advance");
  a_mute_zero: assert property (!sw_s2_ff |-> prod_data == '0)
    else $error("audio produced while disabled");

  c_mode_wrap: cover property (press && mode_ff == MODE_LAST);
  c_lock_done: cover property (vst_ff == VST_LOCK ##1 vst_ff == VST_RUN);
  c_audio_frame: cover property (buf_pop && buf_valid && sw_s2_ff);
endmodule : hpsg_top
`default_nettype wire
